// file: hdl/acr_pkg.sv
`default_nettype none

package acr_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [3:0] ADDR_CONVERSION_RESULT = 4'h0;
	localparam logic [3:0] ADDR_CLOCK_BIAS_MODE   = 4'h1;
	localparam logic [3:0] ADDR_PRESCALE_OSR      = 4'h2;
	localparam logic [3:0] ADDR_BOOST_GAIN_AZ     = 4'h3;
	localparam logic [3:0] ADDR_CONV_FORMAT_CRC   = 4'h4;

	// reset values
	localparam logic [7:0] RST_CLOCK_BIAS_MODE = 8'hC0;
	localparam logic [7:0] RST_PRESCALE_OSR    = 8'h0C;
	localparam logic [7:0] RST_BOOST_GAIN_AZ   = 8'h8B;
	localparam logic [7:0] RST_CONV_FORMAT_CRC = 8'h00;
	localparam logic [24:0] RST_RESULT         = 25'h0000000;

	// ****************************************************************
	// field positions (lsb of each field)
	// ****************************************************************
	localparam int POS_SHUTDOWN_TOP  = 6;
	localparam int POS_CLK_SEL       = 4;
	localparam int POS_BIAS_SEL      = 2;
	localparam int POS_ADC_MODE      = 0;
	localparam int POS_PRESCALE      = 6;
	localparam int POS_OSR           = 2;
	localparam int POS_BOOST         = 6;
	localparam int POS_GAIN          = 3;
	localparam int POS_AUTOZERO      = 2;
	localparam int POS_CONVERSION_MODE_SEL     = 6;
	localparam int POS_DATA_FORMAT   = 4;
	localparam int POS_CRC_WIDTH     = 3;
	localparam int POS_READ_CRC      = 2;
	localparam int POS_OFFSET_CAL    = 1;
	localparam int POS_GAIN_CAL      = 0;

	// ****************************************************************
	// field encodings
	// ****************************************************************
	localparam logic [1:0] MODE_CONVERT  = 2'h3;
	localparam logic [1:0] MODE_STANDBY  = 2'h2;
	localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
	localparam logic [1:0] CONV_CONTINUOUS = 2'h3;
	localparam logic [1:0] CONV_ONE_STANDBY = 2'h2;
	localparam logic [1:0] FMT_CHANNEL_IDENTIFIER_SGN  = 2'h3;
	localparam logic [1:0] FMT_SGN32     = 2'h2;
	localparam logic [1:0] FMT_LEFT32    = 2'h1;
	localparam logic [1:0] CLK_INT_OUT   = 2'h3;
	localparam logic [1:0] CLK_INT       = 2'h2;
	localparam logic [2:0] GAIN_ANALOG_MAX = 3'h5;
	localparam logic [23:0] CLAMP_POS    = 24'hFFFFFF;
	localparam logic [23:0] CLAMP_NEG    = 24'h800000;
	localparam int GAIN_FRAC_BITS        = 23;
	localparam logic [15:0] CRC_POLY     = 16'h8005;
	localparam logic [15:0] CRC_INIT     = 16'h0000;

endpackage

`default_nettype wire

// file: hdl/acr_regs.sv
// Function
// [R1] result refreshed on ready, frozen at read
// [R2] result holds calibrated code when enabled
// [R3] modulator mode: result is four comparator bits
// [R4] host waits after ready before reading
// [R5] top bits inert, all zero means full shutdown
// [R6] clock select internal/output or external
// [R7] bias current select, none by default
// [R8] operating mode convert, standby, shutdown
// [R9] analog clock divides master by 1/2/4/8
// [R10] oversampling code maps to ratio table
// [R11] host writes prescale reserved bits 00
// [R12] boost scales converter bias current
// [R13] gain codes, top two add digital gain
// [R14] autozero doubles time, no continuous
// [R15] host writes boost reserved bits 11
// [R16] mode 11 converts continuously
// [R17] one-shot then operating mode standby
// [R18] one-shot then operating mode shutdown
// [R19] 32-bit sign formats allow overrange
// [R20] 24-bit formats clamp to full scale
// [R21] read crc appended, 16 or 32 wide
`default_nettype none

module acr_regs
	import acr_pkg::*;
#(
	parameter int RAW_W = 25
)(
	input  wire logic               sys_clk,
	input  wire logic               nrst,
	input  wire logic [3:0]         reg_addr,
	input  wire logic               reg_wr_en,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_rd_start,
	output logic      [31:0]        reg_rdata,
	output logic      [5:0]         reg_rdata_bits,
	output logic      [31:0]        read_crc,
	output logic      [5:0]         read_crc_bits,
	input  wire logic               data_ready,
	input  wire logic [RAW_W-1:0]   raw_code,
	input  wire logic [3:0]         channel_identifier,
	input  wire logic [3:0]         modulator_output,
	input  wire logic               modulator_select,
	input  wire logic [23:0]        offset_cal_value,
	input  wire logic [23:0]        gain_cal_value,
	input  wire logic               conversion_done,
	output logic                    full_shutdown,
	output logic                    clock_internal,
	output logic                    clock_out_enable,
	output logic      [1:0]         bias_current_sel,
	output logic                    adc_converting,
	output logic                    adc_standby,
	output logic                    adc_shutdown,
	output logic                    analog_master_clock_en,
	output logic      [16:0]        oversampling_ratio,
	output logic      [1:0]         boost_sel,
	output logic      [2:0]         analog_gain_sel,
	output logic      [1:0]         digital_gain_shift,
	output logic                    conversion_time_double,
	output logic                    continuous_run,
	output logic                    single_repeat
);

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic rst_meta_r;
	logic rst_n_r;

	// two-stage release of the asynchronous reset
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	logic [7:0] cbm_r;
	logic [7:0] pos_r;
	logic [7:0] bga_r;
	logic [7:0] cfc_r;
	logic [1:0] adc_mode;
	logic [1:0] conversion_mode_sel;
	logic       autozero;

	assign adc_mode  = cbm_r[POS_ADC_MODE+:2];
	assign conversion_mode_sel = cfc_r[POS_CONVERSION_MODE_SEL+:2];
	assign autozero  = bga_r[POS_AUTOZERO];

	// clock, bias and mode; end of one-shot overrides the mode field of a same-cycle write, bits 7:2 still written
	always_ff @(posedge sys_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			cbm_r <= RST_CLOCK_BIAS_MODE;
		else if (conversion_done && adc_mode == MODE_CONVERT
			&& conversion_mode_sel != CONV_CONTINUOUS && !autozero)
		begin
			if (reg_wr_en && reg_addr == ADDR_CLOCK_BIAS_MODE)
				cbm_r[7:2] <= reg_wdata[7:2];
			if (conversion_mode_sel == CONV_ONE_STANDBY)
				cbm_r[POS_ADC_MODE+:2] <= MODE_STANDBY; // R17
			else
				cbm_r[POS_ADC_MODE+:2] <= MODE_SHUTDOWN; // R18
		end
		else if (conversion_done && adc_mode == MODE_CONVERT && autozero
			&& conversion_mode_sel != CONV_CONTINUOUS)
		begin
			if (reg_wr_en && reg_addr == ADDR_CLOCK_BIAS_MODE)
				cbm_r[7:2] <= reg_wdata[7:2];
			if (conversion_mode_sel == CONV_ONE_STANDBY)
				cbm_r[POS_ADC_MODE+:2] <= MODE_STANDBY; // R17
			else
				cbm_r[POS_ADC_MODE+:2] <= MODE_SHUTDOWN; // R18
		end
		else if (reg_wr_en && reg_addr == ADDR_CLOCK_BIAS_MODE)
			cbm_r <= reg_wdata; // R5
	end

	// prescaler and oversampling, reserved bits stored as written
	always_ff @(posedge sys_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			pos_r <= RST_PRESCALE_OSR;
		else if (reg_wr_en && reg_addr == ADDR_PRESCALE_OSR)
			pos_r <= reg_wdata;
	end

	// boost, gain and autozero
	always_ff @(posedge sys_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			bga_r <= RST_BOOST_GAIN_AZ;
		else if (reg_wr_en && reg_addr == ADDR_BOOST_GAIN_AZ)
			bga_r <= reg_wdata;
	end

	// conversion mode, format, crc and calibration enables
	always_ff @(posedge sys_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			cfc_r <= RST_CONV_FORMAT_CRC;
		else if (reg_wr_en && reg_addr == ADDR_CONV_FORMAT_CRC)
			cfc_r <= reg_wdata;
	end

	// ****************************************************************
	// decoded controls
	// ****************************************************************
	// full shutdown only when the whole register reads zero
	assign full_shutdown    = (cbm_r == 8'h00); // R5
	assign clock_internal   = cbm_r[POS_CLK_SEL+1]; // R6
	assign clock_out_enable = (cbm_r[POS_CLK_SEL+:2] == CLK_INT_OUT); // R6
	assign bias_current_sel = cbm_r[POS_BIAS_SEL+:2]; // R7
	assign adc_converting   = (adc_mode == MODE_CONVERT) && !full_shutdown; // R8
	assign adc_standby      = (adc_mode == MODE_STANDBY); // R8
	assign adc_shutdown     = !adc_mode[1]; // R8
	assign boost_sel        = bga_r[POS_BOOST+:2]; // R12
	assign conversion_time_double = autozero; // R14
	assign continuous_run   = adc_converting && conversion_mode_sel == CONV_CONTINUOUS && !autozero; // R16
	assign single_repeat    = adc_converting && conversion_mode_sel == CONV_CONTINUOUS && autozero; // R14

	// gain split into analog stage and digital shift
	always_comb
	begin
		if (bga_r[POS_GAIN+:3] > GAIN_ANALOG_MAX)
		begin
			analog_gain_sel    = GAIN_ANALOG_MAX; // R13
			digital_gain_shift = (bga_r[POS_GAIN+:3] == 3'h7) ? 2'h2 : 2'h1; // R13
		end
		else
		begin
			analog_gain_sel    = bga_r[POS_GAIN+:3]; // R13
			digital_gain_shift = 2'h0;
		end
	end

	// oversampling code to ratio
	always_comb
	begin
		case (pos_r[POS_OSR+:4]) // R10
			4'h0:    oversampling_ratio = 17'd32;
			4'h1:    oversampling_ratio = 17'd64;
			4'h2:    oversampling_ratio = 17'd128;
			4'h3:    oversampling_ratio = 17'd256;
			4'h4:    oversampling_ratio = 17'd512;
			4'h5:    oversampling_ratio = 17'd1024;
			4'h6:    oversampling_ratio = 17'd2048;
			4'h7:    oversampling_ratio = 17'd4096;
			4'h8:    oversampling_ratio = 17'd8192;
			4'h9:    oversampling_ratio = 17'd16384;
			4'hA:    oversampling_ratio = 17'd20480;
			4'hB:    oversampling_ratio = 17'd24576;
			4'hC:    oversampling_ratio = 17'd40960;
			4'hD:    oversampling_ratio = 17'd49152;
			4'hE:    oversampling_ratio = 17'd81920;
			4'hF:    oversampling_ratio = 17'd98304;
			default: oversampling_ratio = 17'd256;
		endcase
	end

	// ****************************************************************
	// analog clock prescaler
	// ****************************************************************
	logic [2:0] pre_cnt_r;
	logic [2:0] pre_top;

	assign pre_top = 3'((4'h1 << pos_r[POS_PRESCALE+:2]) - 4'h1); // R9

	// one-cycle enable every 1, 2, 4 or 8 master clocks
	always_ff @(posedge sys_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			pre_cnt_r <= 3'h0;
		else if (pre_cnt_r >= pre_top)
			pre_cnt_r <= 3'h0; // R9
		else
			pre_cnt_r <= pre_cnt_r + 3'h1;
	end

	assign analog_master_clock_en = (pre_cnt_r >= pre_top); // R9

	// ****************************************************************
	// calibration path
	// ****************************************************************
	logic signed [25:0] cal_sum;
	logic signed [50:0] cal_prod;
	logic signed [50:0] cal_shift;
	logic signed [24:0] cal_code;

	// offset add, gain scale, digital gain, saturate to 25 bits
	always_comb
	begin
		cal_sum = 26'(signed'(raw_code));
		if (cfc_r[POS_OFFSET_CAL])
			cal_sum = cal_sum + 26'(signed'(offset_cal_value)); // R2
		cal_prod = 51'(cal_sum);
		if (cfc_r[POS_GAIN_CAL])
			cal_prod = (cal_prod * 51'(signed'({1'b0, gain_cal_value})))
				>>> GAIN_FRAC_BITS; // R2
		cal_shift = cal_prod <<< digital_gain_shift; // R13
		if (cal_shift > 51'sh0FFFFFF)
			cal_code = 25'h0FFFFFF;
		else if (cal_shift < -51'sh1000000)
			cal_code = 25'h1000000;
		else
			cal_code = cal_shift[24:0];
	end

	// ****************************************************************
	// double-buffered result
	// ****************************************************************
	logic [24:0] live_r;
	logic [3:0]  live_channel_identifier_r;

	// refresh on every internal ready
	always_ff @(posedge sys_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			live_r      <= RST_RESULT;
			live_channel_identifier_r <= 4'h0;
		end
		else if (data_ready)
		begin
			live_r      <= cal_code; // R1
			live_channel_identifier_r <= channel_identifier;
		end
	end

	// result formatting
	logic [23:0] clamped;
	logic [31:0] result_word;
	logic [5:0]  result_bits;

	always_comb
	begin
		if (!live_r[24] && live_r[23])
			clamped = CLAMP_POS; // R20
		else if (live_r[24] && !live_r[23])
			clamped = CLAMP_NEG; // R20
		else
			clamped = live_r[23:0];
		case (cfc_r[POS_DATA_FORMAT+:2])
			FMT_CHANNEL_IDENTIFIER_SGN:
			begin
				result_word = {live_channel_identifier_r, {4{live_r[24]}}, live_r[23:0]}; // R19
				result_bits = 6'd32;
			end
			FMT_SGN32:
			begin
				result_word = {{8{live_r[24]}}, live_r[23:0]}; // R19
				result_bits = 6'd32;
			end
			FMT_LEFT32:
			begin
				result_word = {clamped, 8'h00}; // R20
				result_bits = 6'd32;
			end
			default:
			begin
				result_word = {8'h00, clamped}; // R20
				result_bits = 6'd24;
			end
		endcase
		if (modulator_select)
		begin
			result_word = {28'h0000000, modulator_output}; // R3
			result_bits = 6'd4;
		end
	end

	// ****************************************************************
	// read port and crc
	// ****************************************************************
	logic [31:0] rd_nxt;
	logic [5:0]  rd_bits_nxt;
	logic [15:0] crc_nxt;

	// crc-16 over the read word, msb first
	function automatic logic [15:0] acr_crc16(input logic [31:0] d, input logic [5:0] n);
		logic [15:0] c;
		logic        fb;
		c = CRC_INIT;
		for (int i = 31; i >= 0; i--)
		begin
			fb = c[15] ^ d[i];
			if (i < int'(n))
				c = fb ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
		end
		return c;
	endfunction

	// word selected at the start of a read
	always_comb
	begin
		case (reg_addr)
			ADDR_CONVERSION_RESULT:
			begin
				rd_nxt      = result_word;
				rd_bits_nxt = result_bits;
			end
			ADDR_CLOCK_BIAS_MODE:
			begin
				rd_nxt      = {24'h000000, cbm_r};
				rd_bits_nxt = 6'd8;
			end
			ADDR_PRESCALE_OSR:
			begin
				rd_nxt      = {24'h000000, pos_r};
				rd_bits_nxt = 6'd8;
			end
			ADDR_BOOST_GAIN_AZ:
			begin
				rd_nxt      = {24'h000000, bga_r};
				rd_bits_nxt = 6'd8;
			end
			ADDR_CONV_FORMAT_CRC:
			begin
				rd_nxt      = {24'h000000, cfc_r};
				rd_bits_nxt = 6'd8;
			end
			default:
			begin
				rd_nxt      = 32'h00000000;
				rd_bits_nxt = 6'd8;
			end
		endcase
		crc_nxt = acr_crc16(rd_nxt, rd_bits_nxt);
	end

	// snapshot held until the next read start
	always_ff @(posedge sys_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			reg_rdata      <= 32'h00000000;
			reg_rdata_bits <= 6'd0;
			read_crc       <= 32'h00000000;
			read_crc_bits  <= 6'd0;
		end
		else if (reg_rd_start)
		begin
			reg_rdata      <= rd_nxt; // R1
			reg_rdata_bits <= rd_bits_nxt;
			if (!cfc_r[POS_READ_CRC])
			begin
				read_crc      <= 32'h00000000;
				read_crc_bits <= 6'd0;
			end
			else if (cfc_r[POS_CRC_WIDTH])
			begin
				read_crc      <= {crc_nxt, 16'h0000}; // R21
				read_crc_bits <= 6'd32;
			end
			else
			begin
				read_crc      <= {16'h0000, crc_nxt}; // R21
				read_crc_bits <= 6'd16;
			end
		end
	end

endmodule

`default_nettype wire

// file: verification/acr_regs_properties.sv
`default_nettype none
module acr_regs_properties (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_rd_start,
	input wire logic [31:0] reg_rdata,
	input wire logic [5:0]  reg_rdata_bits,
	input wire logic [31:0] read_crc,
	input wire logic [5:0]  read_crc_bits,
	input wire logic [3:0]  modulator_output,
	input wire logic        modulator_select,
	input wire logic        conversion_done,
	input wire logic        full_shutdown,
	input wire logic        clock_internal,
	input wire logic        clock_out_enable,
	input wire logic [1:0]  bias_current_sel,
	input wire logic        adc_converting,
	input wire logic        adc_standby,
	input wire logic        adc_shutdown,
	input wire logic        conversion_time_double,
	input wire logic        continuous_run,
	input wire logic        single_repeat
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// register block checks
	// ********
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	rd_hold_a: assert property (
		!reg_rd_start |=> $stable(reg_rdata) && $stable(read_crc))
		else $error("read word moved without a read");
	mod_read_a: assert property (
		reg_rd_start && modulator_select && reg_addr == 4'h0
		|=> reg_rdata == {28'h0, $past(modulator_output)} && reg_rdata_bits == 6'h04)
		else $error("modulator read wrong");
	fmt_bits_a: assert property (
		reg_rd_start && !modulator_select && reg_addr == 4'h0
		|=> reg_rdata_bits == 6'h18 || reg_rdata_bits == 6'h20)
		else $error("result width wrong");
	full_off_a: assert property (
		full_shutdown |-> adc_shutdown && !clock_internal && bias_current_sel == 2'h0)
		else $error("full shutdown with live fields");
	clk_out_a: assert property (
		clock_out_enable |-> clock_internal)
		else $error("clock output without internal clock");
	mode_one_a: assert property (
		$onehot({adc_converting, adc_standby, adc_shutdown}))
		else $error("operating mode not exclusive");
	az_single_a: assert property (
		single_repeat |-> conversion_time_double && adc_converting && !continuous_run)
		else $error("repeat without autozero");
	cont_run_a: assert property (
		continuous_run |-> adc_converting && !conversion_time_double)
		else $error("continuous run with autozero");
	one_shot_a: assert property (
		conversion_done && adc_converting && !continuous_run && !single_repeat
		|=> !adc_converting)
		else $error("one shot kept converting");
	crc_pad_a: assert property (
		read_crc_bits == 6'h20 |-> read_crc[15:0] == 16'h0)
		else $error("wide crc not padded");
endmodule
`default_nettype wire

// file: verification/acr_host.sv
`default_nettype none
module acr_host #(
	parameter int DAD = 2
)(
	input  wire logic       sys_clk,
	input  wire logic       data_ready,
	output logic      [3:0] reg_addr,
	output var logic        reg_wr_en,
	output logic      [7:0] reg_wdata,
	output var logic        reg_rd_start
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// host side of the register bus
	// ********
	logic [3:0] a_r = 4'h0;
	logic [7:0] d_r = 8'h0;
	int         since = 99;
	// released lines show the inverse of the last value
	assign reg_addr = (reg_wr_en | reg_rd_start) ? a_r : ~a_r;
	assign reg_wdata = reg_wr_en ? d_r : ~d_r;
	initial {reg_wr_en, reg_rd_start} = 2'h0;
	// cycles since the last ready pulse
	always @(posedge sys_clk)
		since <= data_ready ? 0 : since + 1;
	// one write, reserved bits forced
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		a_r <= a;
		d_r <= (a == 4'h2) ? {d[7:2], 2'h0} : (a == 4'h3) ? {d[7:2], 2'h3} : d;
		reg_wr_en <= 1'h1;
		@(posedge sys_clk);
		reg_wr_en <= 1'h0;
		#1;
	endtask
	// one read, kept out of the refresh gap
	task automatic rd(input logic [3:0] a);
		while (since < DAD)
			@(posedge sys_clk);
		@(posedge sys_clk);
		a_r <= a;
		reg_rd_start <= 1'h1;
		@(posedge sys_clk);
		reg_rd_start <= 1'h0;
		#1;
	endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
`default_nettype none
module tb import acr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// bench
	// ********
	logic        sys_clk = 1'h0;
	logic        nrst = 1'h0;
	logic [3:0]  reg_addr;
	logic        reg_wr_en, reg_rd_start;
	logic [7:0]  reg_wdata;
	logic [31:0] reg_rdata, read_crc;
	logic [5:0]  reg_rdata_bits, read_crc_bits;
	logic        data_ready = 1'h0;
	logic        conversion_done = 1'h0;
	logic        modulator_select = 1'h0;
	logic [24:0] raw_code = 25'h0;
	logic [3:0]  channel_identifier = 4'h0;
	logic [3:0]  modulator_output = 4'h0;
	logic [23:0] offset_cal_value = 24'h0;
	logic [23:0] gain_cal_value = 24'h800000;
	logic        full_shutdown, clock_internal, clock_out_enable, adc_converting;
	logic        adc_standby, adc_shutdown, analog_master_clock_en;
	logic        conversion_time_double, continuous_run, single_repeat;
	logic [1:0]  bias_current_sel, boost_sel, digital_gain_shift;
	logic [2:0]  analog_gain_sel;
	logic [16:0] oversampling_ratio;
	logic [7:0]  cfg [1:4];
	logic [75:0] q [$];
	logic        rd_q = 1'h0;
	logic [31:0] seed = 32'h4F;
	int          n_errors = 0;
	int          checked = 0;
	logic [16:0] osr_tab [16] = '{17'h20, 17'h40, 17'h80, 17'h100, 17'h200, 17'h400,
		17'h800, 17'h1000, 17'h2000, 17'h4000, 17'h5000, 17'h6000, 17'hA000, 17'hC000,
		17'h14000, 17'h18000};
	acr_regs dut_u (.*);
	acr_host host_u (.*);
	always #50 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] crc(input logic [31:0] d, input int n);
		logic [15:0] c = 16'h0;
		for (int i = n - 1; i >= 0; i--)
			c = {c[14:0], 1'h0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0);
		return c;
	endfunction
	// expected result word with its width
	function automatic logic [37:0] fmt(input logic [24:0] r, input logic [1:0] f,
		input logic [3:0] ch);
		logic [23:0] k;
		k = (r[24] == r[23]) ? r[23:0] : r[24] ? CLAMP_NEG : CLAMP_POS;
		case (f)
			2'h3: return {ch, {4{r[24]}}, r[23:0], 6'h20};
			2'h2: return {{8{r[24]}}, r[23:0], 6'h20};
			2'h1: return {k, 8'h0, 6'h20};
			default: return {8'h0, k, 6'h18};
		endcase
	endfunction
	task automatic chk(input string nm, input logic [75:0] e, input logic [75:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// note the expected word, then read
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [5:0] n);
		logic [15:0] c;
		c = crc(d, n);
		q.push_back({d, n, !cfg[4][2] ? 38'h0 : cfg[4][3] ? {c, 16'h0, 6'h20}
			: {16'h0, c, 6'h10}});
		host_u.rd(a);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host_u.wr(a, d);
		if (a inside {[1:4]})
			cfg[a] = d;
	endtask
	task automatic cv(input logic [24:0] r, input logic [3:0] ch);
		@(posedge sys_clk);
		{raw_code, channel_identifier, data_ready} <= {r, ch, 1'h1};
		@(posedge sys_clk);
		{raw_code, data_ready} <= {~r, 1'h0};
		#1;
	endtask
	task automatic report_and_stop();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// compare each finished read with the oldest note
	always @(posedge sys_clk)
		rd_q <= reg_rd_start;
	always @(negedge sys_clk)
		if (rd_q)
			chk("read", q.pop_front(), {reg_rdata, reg_rdata_bits, read_crc, read_crc_bits});
	initial
	begin
		#(5000 * 100);
		n_errors++;
		report_and_stop();
	end
	initial
	begin
		logic [7:0]  d;
		logic [24:0] r;
		logic [37:0] e;
		int          n;
		repeat (6) @(posedge sys_clk);
		nrst <= 1'h1;
		repeat (3) @(posedge sys_clk);
		cfg = '{8'hC0, 8'h0C, 8'h8B, 8'h00};
		for (int a = 1; a <= 4; a++)
			rd(4'(a), {24'h0, cfg[a]}, 6'h08);
		rd(4'h0, 32'h0, 6'h18);
		rd(4'h7, 32'h0, 6'h08);
		// random contents, index 0 refuses writes
		for (int a = 0; a <= 4; a++)
		begin
			d = 8'(rnd());
			d[1:0] = (a == 2) ? 2'h0 : (a == 3) ? 2'h3 : d[1:0];
			wr(4'(a), d);
		end
		for (int a = 1; a <= 4; a++)
			rd(4'(a), {24'h0, cfg[a]}, 6'h08);
		// every code of every first-register field
		for (int k = 0; k < 16; k++)
		begin
			d = {k[3:2], k[1:0], k[3:2], k[1:0]};
			wr(4'h1, d);
			chk("modes", 76'({full_shutdown, clock_internal, clock_out_enable, bias_current_sel,
				adc_converting, adc_standby, adc_shutdown}), 76'({d == 8'h0, d[5], d[5:4] == 2'h3,
				d[3:2], d[1:0] == 2'h3, d[1:0] == 2'h2, !d[1]}));
		end
		for (int k = 0; k < 16; k++)
		begin
			wr(4'h2, {k[1:0], k[3:0], 2'h0});
			n = 0;
			repeat (8) @(negedge sys_clk);
			repeat (16) @(negedge sys_clk) n += 32'(analog_master_clock_en);
			chk("ratio", 76'(osr_tab[k]), 76'(oversampling_ratio));
			chk("pulses", 76'(16 >> k[1:0]), 76'(n));
		end
		for (int k = 0; k < 8; k++)
		begin
			wr(4'h3, {k[1:0], k[2:0], k[0], 2'h3});
			chk("gain", 76'({k[1:0], (k > 5) ? 3'h5 : k[2:0], (k == 7) ? 2'h2 : {1'h0, k == 6},
				k[0]}), 76'({boost_sel, analog_gain_sel, digital_gain_shift,
				conversion_time_double}));
		end
		// end of conversion in each mode, with and without autozero
		for (int k = 0; k < 8; k++)
		begin
			wr(4'h3, {5'h11, k[2], 2'h3});
			wr(4'h4, {k[1:0], 6'h0});
			wr(4'h1, 8'hC3);
			chk("run", 76'({k[1:0] == 2'h3 && !k[2], k[1:0] == 2'h3 && k[2]}),
				76'({continuous_run, single_repeat}));
			@(posedge sys_clk);
			conversion_done <= 1'h1;
			@(posedge sys_clk);
			conversion_done <= 1'h0;
			#1;
			d = (k[1:0] == 2'h3) ? 8'hC3 : k[1] ? 8'hC2 : 8'hC0;
			cfg[1] = d;
			rd(4'h1, {24'h0, d}, 6'h08);
		end
		// formats, overrange, crc, latest refresh wins
		for (int k = 0; k < 16; k++)
		begin
			wr(4'h4, {2'h3, k[1:0], k[3:2], 2'h0});
			r = 25'(rnd());
			if (k[3])
				r[24] = r[23];
			else
				r = k[2] ? 25'h1200000 : 25'h0900000;
			cv(~r, 4'hF);
			cv(r, 4'(k));
			e = fmt(r, k[1:0], 4'(k));
			rd(4'h0, e[37:6], e[5:0]);
		end
		@(posedge sys_clk);
		offset_cal_value <= 24'h000010;
		gain_cal_value <= 24'h400000;
		for (int k = 1; k < 4; k++)
		begin
			wr(4'h4, 8'(k));
			cv(25'h0000100, 4'h1);
			rd(4'h0, (k == 3) ? 32'h88 : (k == 2) ? 32'h110 : 32'h80, 6'h18);
		end
		d = 8'(rnd());
		@(posedge sys_clk);
		modulator_select <= 1'h1;
		modulator_output <= d[3:0];
		rd(4'h0, {28'h0, d[3:0]}, 6'h04);
		repeat (4) @(posedge sys_clk);
		report_and_stop();
	end
endmodule
bind acr_regs acr_regs_properties prop_u (.*);
`default_nettype wire
